// ==== calm_ctrl.sv ====
/*
  Calibration memory access controller: access and data/status registers,
  read and write cycle sequencing, and content-layout decode of each byte read.
  Assumes a register port from the host bus target and a parallel memory
  port whose read data is valid at the end of the read interval.
*/
`timescale 1ns/1ps
module calm_ctrl
  import calm_pkg::*;
#(
  parameter int unsigned READ_CYC  = CALM_READ_CYC,   // Read interval
  parameter int unsigned WRITE_CYC = CALM_WRITE_CYC,  // Write interval
  parameter int unsigned GUARD_CYC = CALM_GUARD_CYC   // Status read access
) (
  input  wire logic        clk_sys_i,     // System clock
  input  wire logic        reset_n_i,     // Hardware reset, active low
  input  wire logic        soft_reset_i,  // Software reset pulse
  input  wire logic        reg_wr_i,      // Register write strobe
  input  wire logic        reg_rd_i,      // Register read strobe
  input  wire logic [7:0]  reg_addr_i,    // Register byte offset
  input  wire logic [15:0] reg_wdata_i,   // Write data
  input  wire logic [1:0]  reg_be_i,      // Byte enables
  output logic      [15:0] reg_rdata_o,   // Read data
  output logic             reg_rvalid_o,  // Read data valid pulse
  input  wire logic [15:0] unlock_code_i, // Factory write enable code
  output logic             mem_rd_o,      // Memory read access active
  output logic             mem_wr_o,      // Memory write access active
  output logic      [6:0]  mem_addr_o,    // Memory address
  output logic      [7:0]  mem_wdata_o,   // Memory write byte
  input  wire logic [7:0]  mem_rdata_i,   // Memory read byte
  output calm_kind_e       read_kind_o,   // Kind of last byte read
  output logic             ref_lead_o,    // Last byte was a leading digit
  output logic      [2:0]  coef_chan_o,   // Address bits 4:2 of last byte read (coefficient channel)
  output logic             coef_gain_o    // Last byte read was a gain coefficient
);

  localparam int CW = CALM_CNT_W;

  calm_state_e      state_q, state_d;
  logic [15:0]      acc_q;
  logic [6:0]       op_addr_q;
  logic [7:0]       op_wdat_q;
  logic [7:0]       data_q;
  logic             done_q;
  logic             busy_q;
  logic [15:0]      rdata_q;
  logic             rvalid_q;
  calm_kind_e       kind_q;
  logic             lead_q;
  logic [2:0]       chan_q;
  logic             gain_q;
  logic             acc_set_q;

  // Register decode; partial-width writes are dropped
  logic acc_wr_w, stat_rd_w, wide_w;
  assign wide_w    = &reg_be_i;
  assign acc_wr_w  = reg_wr_i && wide_w && (reg_addr_i == CALM_ACC_OFS);
  assign stat_rd_w = reg_rd_i && (reg_addr_i == CALM_STAT_OFS);

  // Request decode
  logic req_rd_w, key_ok_w, guard_busy_w, idle_w;
  logic start_w, rd_start_w, wr_start_w;
  assign req_rd_w   = reg_wdata_i[CALM_DIR_BIT];
  assign key_ok_w   = (unlock_code_i == CALM_UNLOCK_CODE);
  assign idle_w     = (state_q == CALM_IDLE);
  assign start_w    = acc_wr_w && idle_w && !guard_busy_w && !soft_reset_i;
  assign rd_start_w = start_w && req_rd_w;
  assign wr_start_w = start_w && !req_rd_w && key_ok_w;

  // Interval timer for read and write cycles
  logic          op_done_w, op_busy_w;
  logic [CW-1:0] op_len_w;
  assign op_len_w = req_rd_w ? CW'(READ_CYC) : CW'(WRITE_CYC);

  calm_timer #(.W(CW)) u_op_timer (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .start_i   (rd_start_w || wr_start_w),
    .abort_i   (soft_reset_i),
    .len_i     (op_len_w),
    .busy_o    (op_busy_w),
    .done_o    (op_done_w)
  );

  // Access started by each status read; refuses new cycles meanwhile
  calm_timer #(.W(CW)) u_guard_timer (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .start_i   (stat_rd_w),
    .abort_i   (1'b0),
    .len_i     (CW'(GUARD_CYC)),
    .busy_o    (guard_busy_w),
    .done_o    ()
  );

  // Access register keeps its value through every reset
  always_ff @(posedge clk_sys_i) begin
    if (acc_wr_w) begin
      acc_q <= reg_wdata_i;
    end
  end

  // Marks the access register as loaded, so its hold check never sees power-up junk
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_set_q <= 1'b0;
    end else if (acc_wr_w) begin
      acc_set_q <= 1'b1;
    end
  end

  // Cycle sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CALM_IDLE: begin
        if (rd_start_w) begin
          state_d = CALM_READ;
        end else if (wr_start_w) begin
          state_d = CALM_WRITE;
        end
      end
      CALM_READ, CALM_WRITE: begin
        if (op_done_w) begin
          state_d = CALM_IDLE;
        end
      end
    endcase
    if (soft_reset_i) begin
      state_d = CALM_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= CALM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Latched cycle address and write byte
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_addr_q <= '0;
      op_wdat_q <= '0;
    end else if (start_w) begin
      op_addr_q <= reg_wdata_i[CALM_ADDR_HI:CALM_ADDR_LO];
      op_wdat_q <= reg_wdata_i[CALM_WDAT_HI:0];
    end
  end

  // Memory port
  assign mem_rd_o    = (state_q == CALM_READ) || guard_busy_w;
  assign mem_wr_o    = (state_q == CALM_WRITE);
  assign mem_addr_o  = op_addr_q;
  assign mem_wdata_o = op_wdat_q;

  // Data/status flags
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_q <= CALM_STAT_RST[15:CALM_RDAT_LO];
      done_q <= CALM_STAT_RST[CALM_DONE_BIT];
      busy_q <= CALM_STAT_RST[CALM_BUSY_BIT];
    end else if (soft_reset_i) begin
      data_q <= CALM_STAT_RST[15:CALM_RDAT_LO];
      done_q <= CALM_STAT_RST[CALM_DONE_BIT];
      busy_q <= CALM_STAT_RST[CALM_BUSY_BIT];
    end else begin
      if (rd_start_w) begin
        done_q <= 1'b0;
      end else if (op_done_w && state_q == CALM_READ) begin
        data_q <= mem_rdata_i;
        done_q <= 1'b1;
      end
      if (wr_start_w) begin
        busy_q <= 1'b1;
      end else if (op_done_w && state_q == CALM_WRITE) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Status word; bits 7:2 are always zero
  logic [15:0] stat_w;
  assign stat_w = {data_q, 6'h00, busy_q, done_q};

  // Register read data
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q  <= CALM_RD_UNMAP;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= stat_rd_w ? stat_w : CALM_RD_UNMAP;
      rvalid_q <= reg_rd_i;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // Layout decode of the cycle address: one window per reference string
  logic [CALM_REF_NUM-1:0] ref_hit_w;
  logic [CALM_REF_NUM-1:0] ref_lead_w;
  for (genvar i = 0; i < CALM_REF_NUM; i++) begin : g_ref
    assign ref_hit_w[i]  = 7'(op_addr_q - CALM_REF_BASE[i]) < CALM_REF_LEN;
    assign ref_lead_w[i] = (op_addr_q == CALM_REF_BASE[i]);
  end

  logic       coef_w;
  calm_kind_e kind_w;
  assign coef_w = (op_addr_q <= CALM_COEF_LAST);
  assign kind_w = coef_w ? (op_addr_q[0] ? CALM_KIND_COEF_LSB
                                         : CALM_KIND_COEF_MSB) :
                  !(|ref_hit_w) ? CALM_KIND_NONE :
                  (mem_rdata_i == CALM_STR_TERM) ? CALM_KIND_REF_END
                                                 : CALM_KIND_REF_CHAR;

  // Byte classification, updated as each read completes
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      kind_q <= CALM_KIND_NONE;
      lead_q <= 1'b0;
      chan_q <= '0;
      gain_q <= 1'b0;
    end else if (op_done_w && state_q == CALM_READ) begin
      kind_q <= kind_w;
      lead_q <= |ref_lead_w;
      chan_q <= op_addr_q[4:2];
      gain_q <= coef_w && op_addr_q[1];
    end
  end

  assign read_kind_o = kind_q;
  assign ref_lead_o  = lead_q;
  assign coef_chan_o = chan_q;
  assign coef_gain_o = gain_q;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence rd_begin_s;
    rd_start_w ##1 (state_q == CALM_READ);
  endsequence

  sequence wr_begin_s;
    wr_start_w ##1 busy_q;
  endsequence

  acc_hold_a: assert property (acc_set_q && !acc_wr_w |=> $stable(acc_q))
    else $error("access register changed without a write");

  rd_clear_a: assert property (rd_start_w |=> !done_q && mem_rd_o)
    else $error("read start did not clear complete flag");

  rd_span_a: assert property (disable iff (!reset_n_i || soft_reset_i)
                              rd_begin_s |-> mem_rd_o [*8])
    else $error("read access ended too early");

  done_src_a: assert property ($rose(done_q) |->
                               $past(op_done_w) && $past(state_q == CALM_READ))
    else $error("complete flag rose without a finished read");

  rd_data_a: assert property ($rose(done_q) |-> data_q == $past(mem_rdata_i))
    else $error("read byte not captured at completion");

  wr_busy_a: assert property (disable iff (!reset_n_i || soft_reset_i)
                              wr_begin_s |-> (busy_q && mem_wr_o) [*8])
    else $error("write busy dropped too early");

  busy_end_a: assert property ($fell(busy_q) && !$past(soft_reset_i) |->
                               $past(op_done_w))
    else $error("write busy fell before the interval ended");

  key_gate_a: assert property (acc_wr_w && idle_w && !guard_busy_w && !req_rd_w
                               && !key_ok_w |=> !busy_q && idle_w)
    else $error("write started without enable code");

  guard_a: assert property (stat_rd_w |=> guard_busy_w && mem_rd_o)
    else $error("status read did not start an access");

  soft_clr_a: assert property (soft_reset_i |=> stat_w == CALM_STAT_RST)
    else $error("software reset left status bits set");

  pad_zero_a: assert property (reg_rvalid_o |-> reg_rdata_o[7:2] == 6'h00)
    else $error("unused status bits not zero");

  soft_abort_a: assert property (soft_reset_i |=> idle_w && !mem_wr_o)
    else $error("software reset left a cycle running");

  // Refused requests and routing of the request fields
  guard_refuse_a: assert property (acc_wr_w && guard_busy_w && idle_w |=> idle_w)
    else $error("cycle started during status read access");

  busy_refuse_a: assert property (acc_wr_w && busy_q |=> $stable(op_addr_q))
    else $error("request taken while write busy");

  rd_addr_a: assert property (rd_start_w |=>
                              mem_addr_o == $past(reg_wdata_i[CALM_ADDR_HI:CALM_ADDR_LO]))
    else $error("read address not taken from request");

  wr_field_a: assert property (wr_start_w |=>
                               mem_addr_o == $past(reg_wdata_i[CALM_ADDR_HI:CALM_ADDR_LO])
                               && mem_wdata_o == $past(reg_wdata_i[CALM_WDAT_HI:0]))
    else $error("write address or byte not taken from request");

  // Classification outputs agree with each other
  lead_kind_a: assert property (ref_lead_o |->
                                read_kind_o inside {CALM_KIND_REF_CHAR, CALM_KIND_REF_END})
    else $error("leading digit flag outside a reference string");

  gain_kind_a: assert property (coef_gain_o |->
                                read_kind_o inside {CALM_KIND_COEF_MSB, CALM_KIND_COEF_LSB})
    else $error("gain flag outside the coefficient area");

  str_end_a: assert property (read_kind_o == CALM_KIND_REF_END |->
                              data_q == CALM_STR_TERM)
    else $error("string end reported on a nonzero byte");

endmodule : calm_ctrl

// ==== calm_pkg.sv ====
/*
  Shared constants and types for the calibration memory access block.
  Assumes a 125 MHz system clock; all times are converted to cycles here.
*/
package calm_pkg;

  // Register byte offsets
  localparam logic [7:0]  CALM_ACC_OFS     = 8'h64;
  localparam logic [7:0]  CALM_STAT_OFS    = 8'h68;

  // Access register field positions
  localparam int          CALM_DIR_BIT     = 15;
  localparam int          CALM_ADDR_HI     = 14;
  localparam int          CALM_ADDR_LO     = 8;
  localparam int          CALM_WDAT_HI     = 7;

  // Data/status field positions and reset value
  localparam int          CALM_DONE_BIT    = 0;
  localparam int          CALM_BUSY_BIT    = 1;
  localparam int          CALM_RDAT_LO     = 8;
  localparam logic [15:0] CALM_STAT_RST    = 16'h0000;
  localparam logic [15:0] CALM_RD_UNMAP    = 16'h0000;

  // Timing
  localparam int          CALM_CLK_NS      = 8;
  localparam int          CALM_READ_NS     = 2500000;
  localparam int          CALM_WRITE_NS    = 5000000;
  localparam int          CALM_GUARD_NS    = 1000000;
  localparam int          CALM_READ_CYC    = (CALM_READ_NS + CALM_CLK_NS - 1) / CALM_CLK_NS;
  localparam int          CALM_WRITE_CYC   = (CALM_WRITE_NS + CALM_CLK_NS - 1) / CALM_CLK_NS;
  localparam int          CALM_GUARD_CYC   = (CALM_GUARD_NS + CALM_CLK_NS - 1) / CALM_CLK_NS;
  localparam int          CALM_CNT_W       = 20;

  // Memory content layout
  localparam logic [6:0]  CALM_COEF_LAST   = 7'h1F;
  localparam int          CALM_REF_NUM     = 4;
  localparam logic [6:0]  CALM_REF_BASE [CALM_REF_NUM] = '{7'h20, 7'h30, 7'h40, 7'h50};
  localparam logic [6:0]  CALM_REF_LEN     = 7'h08;
  localparam logic [7:0]  CALM_STR_TERM    = 8'h00;

  // Factory write enable code (value is arbitrary)
  localparam logic [15:0] CALM_UNLOCK_CODE = 16'hC0DE;

  typedef enum logic [1:0] {
    CALM_IDLE,
    CALM_READ,
    CALM_WRITE
  } calm_state_e;

  typedef enum logic [2:0] {
    CALM_KIND_NONE,
    CALM_KIND_COEF_MSB,
    CALM_KIND_COEF_LSB,
    CALM_KIND_REF_CHAR,
    CALM_KIND_REF_END
  } calm_kind_e;

endpackage : calm_pkg

// ==== calm_timer.sv ====
/*
  Down-counting interval timer: runs for a loaded number of cycles.
  Assumes len_i is at least 1 when start_i pulses.
*/
`timescale 1ns/1ps
module calm_timer #(
  parameter int W = 20
) (
  input  wire logic         clk_sys_i,  // System clock
  input  wire logic         reset_n_i,  // Async reset, active low
  input  wire logic         start_i,    // Load and start
  input  wire logic         abort_i,    // Stop at once
  input  wire logic [W-1:0] len_i,      // Interval in cycles
  output logic              busy_o,     // High while running
  output logic              done_o      // Pulse on the last cycle
);

  logic [W-1:0] cnt_q;
  logic         run_q;

  // Busy while running; done on the last cycle of the interval
  assign busy_o = run_q;
  assign done_o = run_q && (cnt_q == '0) && !abort_i;

  // Counter and run flag
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (abort_i) begin
      run_q <= 1'b0;
    end else if (start_i) begin
      cnt_q <= len_i - W'(1);
      run_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - W'(1);
      run_q <= (cnt_q != '0);
    end
  end

endmodule : calm_timer

// ==== calm_mem_model.sv ====
/*
  Behavioural calibration memory that stands behind the controller.
  Assumes level accesses with fixed timing and no handshake.
*/
`timescale 1ns/1ps
module calm_mem_model (
  input  wire logic       clk_sys_i,    // System clock
  input  wire logic       mem_rd_i,     // Read access active
  input  wire logic       mem_wr_i,     // Write access active
  input  wire logic [6:0] mem_addr_i,   // Byte address
  input  wire logic [7:0] mem_wdata_i,  // Byte to store
  output logic      [7:0] mem_rdata_o   // Byte read
);
  logic [7:0] mem [128];
  logic [7:0] idle_q;
  logic       wr_q;
  string      refs [4];

  // Preload coefficients and null-ended reference strings
  initial begin
    refs = '{"9.88335", "4.94167", "2.47083", "1.23541"};
    foreach (mem[i]) mem[i] = 8'hFF;
    for (int i = 0; i < 32; i++) mem[i] = 8'h40 + 8'(i);
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 7; c++) mem[32 + 16 * r + c] = refs[r][c];
      mem[32 + 16 * r + 7] = 8'h00;
    end
    idle_q = 8'h5A;
    wr_q   = 1'b0;
  end

  // Store at write start; data line toggles when not read
  always @(posedge clk_sys_i) begin
    idle_q <= ~idle_q;
    wr_q   <= mem_wr_i;
    if (mem_wr_i && !wr_q) mem[mem_addr_i] <= mem_wdata_i;
  end

  assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : idle_q;
endmodule : calm_mem_model

// ==== testbench.sv ====
/*
  Self-checking bench for the calibration memory access controller.
  Assumes shortened cycle counts and the memory model beside the design.
*/
`timescale 1ns/1ps
module testbench;
  import calm_pkg::*;
  localparam int RC = 40;
  localparam int WC = 60;
  localparam int GC = 20;
  logic clk_sys_i = 0, reset_n_i = 0, soft_reset_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 8'h00, mem_rdata_i;
  logic [15:0] reg_wdata_i = 16'h0000, unlock_code_i = 16'h0000, reg_rdata_o;
  logic [1:0] reg_be_i = 2'b00;
  logic reg_rvalid_o, mem_rd_o, mem_wr_o, ref_lead_o, coef_gain_o;
  logic [6:0] mem_addr_o;
  logic [7:0] mem_wdata_o, lfsr = 8'd90;
  logic [2:0] coef_chan_o;
  calm_kind_e read_kind_o;
  logic [31:0] exp_q [$];
  int n_errors = 0, num_checks = 0, cycles = 0;
  logic [6:0] rd_addrs [8] = '{7'h00, 7'h05, 7'h0E, 7'h1F, 7'h20, 7'h27, 7'h34, 7'h50};

  calm_ctrl #(.READ_CYC(RC), .WRITE_CYC(WC), .GUARD_CYC(GC)) u_dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .soft_reset_i(soft_reset_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_be_i(reg_be_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .unlock_code_i(unlock_code_i), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .read_kind_o(read_kind_o), .ref_lead_o(ref_lead_o),
    .coef_chan_o(coef_chan_o), .coef_gain_o(coef_gain_o));

  calm_mem_model u_mem (
    .clk_sys_i(clk_sys_i), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  // Clock and hang guard
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc

  task automatic wr(input logic [15:0] d, input logic [1:0] be);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= CALM_ACC_OFS;
    reg_wdata_i <= d;
    reg_be_i    <= be;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  // Note expected word and mask, then strobe the read
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back({e, m});
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    reg_be_i   <= 2'b11;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask : rd

  // Compare each returned word against the oldest note
  always @(posedge clk_sys_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected read", 16'h0001, 16'h0000);
      else check("read word", reg_rdata_o & exp_q[0][15:0], exp_q[0][31:16] & exp_q[0][15:0]);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  function automatic logic [2:0] exp_kind(input logic [6:0] a, input logic [7:0] b);
    if (a <= 7'h1F) return a[0] ? 3'd2 : 3'd1;
    if (a <= 7'h57 && !a[3]) return (b == 8'h00) ? 3'd4 : 3'd3;
    return 3'd0;
  endfunction : exp_kind

  // Next state of the stimulus shift register
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  // Full read cycle with an early status look and classification checks
  task automatic do_read(input logic [6:0] a);
    logic [7:0] b;
    b = u_mem.mem[a];
    wr({1'b1, a, 8'h00}, 2'b11);
    check("read start", 16'(mem_rd_o), 16'h0001);
    check("read addr", 16'(mem_addr_o), 16'(a));
    cyc(RC - 4);
    rd(CALM_STAT_OFS, 16'h0000, 16'h0003);
    cyc(3);
    #1;
    check("kind", 16'(read_kind_o), 16'(exp_kind(a, b)));
    check("lead", 16'(ref_lead_o), 16'(a > 7'h1F && a[3:0] == 4'h0));
    check("chan", 16'(coef_chan_o), 16'(a[4:2]));
    check("gain", 16'(coef_gain_o), 16'(a <= 7'h1F && a[1]));
    rd(CALM_STAT_OFS, {b, 8'h01}, 16'hFFFF);
    cyc(GC + 3);
  endtask : do_read

  initial begin
    cyc(8);
    reset_n_i <= 1'b1;
    rd(CALM_STAT_OFS, 16'h0000, 16'hFFFF);
    rd(CALM_ACC_OFS, 16'h0000, 16'hFFFF);
    cyc(GC + 3);
    wr(16'h8500, 2'b01);
    check("partial write", 16'(mem_rd_o), 16'h0000);
    foreach (rd_addrs[i]) begin
      do_read(rd_addrs[i]);
    end
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      do_read(7'(lfsr % 8'h58));
    end
    // Write refused without the enable code
    wr({1'b0, 7'h7F, 8'hA5}, 2'b11);
    cyc(2);
    check("locked write", 16'(mem_wr_o), 16'h0000);
    unlock_code_i <= CALM_UNLOCK_CODE;
    wr({1'b0, 7'h7F, 8'hA5}, 2'b11);
    check("write start", 16'(mem_wr_o), 16'h0001);
    wr(16'h8500, 2'b11);
    check("read while busy", 16'(mem_rd_o), 16'h0000);
    cyc(6);
    rd(CALM_STAT_OFS, 16'h0003, 16'h0003);
    cyc(WC - 11);
    #1;
    check("write span", 16'(mem_wr_o), 16'h0001);
    cyc(1);
    #1;
    check("write end", 16'(mem_wr_o), 16'h0000);
    rd(CALM_STAT_OFS, 16'h0001, 16'h0003);
    cyc(GC + 3);
    do_read(7'h7F);
    // Software reset aborts a write and clears status
    wr({1'b0, 7'h10, 8'h3C}, 2'b11);
    cyc(5);
    soft_reset_i <= 1'b1;
    cyc(1);
    soft_reset_i <= 1'b0;
    cyc(1);
    #1;
    check("soft abort", 16'(mem_wr_o), 16'h0000);
    rd(CALM_STAT_OFS, 16'h0000, 16'hFFFF);
    wr({1'b0, 7'h11, 8'h5A}, 2'b11);
    check("write in guard", 16'(mem_wr_o), 16'h0000);
    cyc(GC + 3);
    // Hardware reset after a completed read
    do_read(7'h21);
    reset_n_i <= 1'b0;
    cyc(3);
    reset_n_i <= 1'b1;
    rd(CALM_STAT_OFS, 16'h0000, 16'hFFFF);
    cyc(4);
    check("queue drained", 16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule : testbench
